// ==== core/xrsd_decode.sv ====
// Decoder and clock-count sequencer for the string/shift/set decode slice
`timescale 1ns/1ps
// How it works
// - F3 compare string repeats while equal, 11+4n.
// - F3 scan string repeats while equal, 9+3n.
// - F2 compare string repeats while unequal, 11+4n.
// - F2 scan string repeats while unequal, 9+3n.
// - Near return with stack adjust takes 3.
// - Far return: 10 real, 13 protected.
// - Far return changing privilege takes 35.
// - Shift group field 000 rotates left, 2.
// - Shift group field 001 rotates right, 2.
// - 0F 79 restores segment and descriptor, 11.
// - 0F 7B restores local table, 11.
// - 0F 7D restores task register, 11.
// - 0F AA resumes, restores all flags, 57.
// - 9E copies AH to flags, 1, keeps OF.
// - Field 100 shifts left: 1, 2 by CL.
// - Field 111 shifts right arithmetic, 2.
// - Subtract with borrow forms take 1.
// - Accumulator immediate subtract with borrow, 1.
// - Set byte on carry, carry-or-zero, 1.
// - Set byte on zero, 1, flags unchanged.
// - Set byte signed less, less-equal, 1.
module xrsd_decode #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // Request
  input  wire logic                  req_valid_i,
  input  wire xrsd_pkg::xrsd_req_type req_i,
  input  wire logic      [CNT_W-1:0] count_i,
  output logic                       req_ready_o,
  // Per-element compare
  output logic                       elem_strobe_o,
  input  wire logic                  elem_eq_i,
  // Result
  output logic                       done_o,
  output xrsd_pkg::xrsd_res_type     res_o,
  output logic               [31:0]  clocks_o,
  output logic           [CNT_W-1:0] count_o
);
  import xrsd_pkg::*;

  xrsd_op_type    dec_op;
  logic [7:0]     dec_base;
  logic [7:0]     dec_iter;
  logic           dec_fault;
  logic           accept;
  xrsd_state_type state_q, state_d;
  logic [7:0]     timer_q, timer_d;
  logic [7:0]     iter_q;
  logic           rpt_q;
  logic           want_eq_q;
  logic           iter_start;
  logic           finish;
  logic           step;
  logic           cnt_zero;
  logic           cnt_stop;
  logic           ready_q;
  logic           done_q;
  logic           strobe_q;
  logic [31:0]    clocks_q;
  xrsd_res_type   res_q;
  logic           ah_op;
  logic [31:0]    busy_q;
  logic [31:0]    iters_q;
  logic           prot_q;
  logic           priv_q;
  logic           by_cl_q;

  assign accept = req_valid_i && ready_q;
  assign step   = (state_q == ST_ITER) && (timer_q == 8'h00);
  assign ah_op  = !req_i.esc && (req_i.opcode == OPC_AH_FLAGS);

  // Opcode and register field to operation and clock counts
  always_comb begin
    dec_op    = OP_NONE;
    dec_base  = 8'h00;
    dec_iter  = 8'h00;
    dec_fault = 1'b0;
    if (!req_i.esc) begin
      if (req_i.opcode[7:1] == OPC_CMP_STR_HI && req_i.prefix == PFX_RPT_EQ) begin
        dec_op = OP_RPT_EQ_CMP;
        dec_base = CYC_CMP_BASE;
        dec_iter = CYC_CMP_ITER;
      end else if (req_i.opcode[7:1] == OPC_CMP_STR_HI && req_i.prefix == PFX_RPT_NE) begin
        dec_op = OP_RPT_NE_CMP;
        dec_base = CYC_CMP_BASE;
        dec_iter = CYC_CMP_ITER;
      end else if (req_i.opcode[7:1] == OPC_SCAN_STR_HI && req_i.prefix == PFX_RPT_EQ) begin
        dec_op = OP_RPT_EQ_SCAN;
        dec_base = CYC_SCAN_BASE;
        dec_iter = CYC_SCAN_ITER;
      end else if (req_i.opcode[7:1] == OPC_SCAN_STR_HI && req_i.prefix == PFX_RPT_NE) begin
        dec_op = OP_RPT_NE_SCAN;
        dec_base = CYC_SCAN_BASE;
        dec_iter = CYC_SCAN_ITER;
      end else if (req_i.opcode[7:1] == OPC_SCAN_STR_HI) begin
        dec_op = OP_SCAN;
        dec_base = CYC_SCAN_ONE;
      end else if (req_i.opcode == OPC_RTN_NEAR || req_i.opcode == OPC_RTN_NEAR_IMM) begin
        dec_op = OP_RETURN_NEAR;
        dec_base = CYC_RTN_NEAR;
      end else if (req_i.opcode == OPC_RTN_FAR || req_i.opcode == OPC_RTN_FAR_IMM) begin
        dec_op = OP_RETURN_FAR;
        if (!req_i.prot_mode) begin
          dec_base = CYC_FAR_REAL;
        end else if (req_i.priv_change) begin
          dec_base = CYC_FAR_PRIV;
        end else begin
          dec_base = CYC_FAR_PROT;
        end
      end else if (req_i.opcode[7:1] == OPC_SHF_ONE_HI || req_i.opcode[7:1] == OPC_SHF_CL_HI
                   || req_i.opcode[7:1] == OPC_SHF_IMM_HI) begin
        case (req_i.reg_field)
          RF_ROT_L: begin
            dec_op = OP_ROT_LEFT;
            dec_base = CYC_ROT;
          end
          RF_ROT_R: begin
            dec_op = OP_ROT_RIGHT;
            dec_base = CYC_ROT;
          end
          RF_ASH_L: begin
            dec_op = OP_ASHIFT_LEFT;
            dec_base = (req_i.opcode[7:1] == OPC_SHF_CL_HI) ? CYC_ASH_L_CL : CYC_ASH_L;
          end
          RF_ASH_R: begin
            dec_op = OP_ASHIFT_RIGHT;
            dec_base = CYC_ASH_R;
          end
          default: begin
            dec_op = OP_NONE;
          end
        endcase
      end else if (ah_op) begin
        dec_op = OP_AH_TO_FLAGS;
        dec_base = CYC_ONE;
      end else if (req_i.opcode[7:2] == OPC_SUBB_RM_HI || req_i.opcode[7:1] == OPC_SUBB_ACC_HI
                   || (req_i.opcode[7:2] == OPC_ALU_IMM_HI && req_i.reg_field == RF_SUBB)) begin
        dec_op = OP_SUB_BORROW;
        dec_base = CYC_ONE;
      end
    end else begin
      if (req_i.opcode == OPC2_RST_SEG) begin
        dec_op = OP_RESTORE_SEG;
        dec_base = CYC_RESTORE;
      end else if (req_i.opcode == OPC2_RST_LDT && req_i.reg_field == RF_ZERO) begin
        dec_op = OP_RESTORE_LDT;
        dec_base = CYC_RESTORE;
      end else if (req_i.opcode == OPC2_RST_TASK && req_i.reg_field == RF_ZERO) begin
        dec_op = OP_RESTORE_TASK;
        dec_base = CYC_RESTORE;
      end else if (req_i.opcode == OPC2_RESUME) begin
        dec_op = OP_RESUME_MGMT;
        dec_base = CYC_RESUME;
      end else if (req_i.reg_field == RF_ZERO) begin
        dec_base = CYC_ONE;
        case (req_i.opcode)
          OPC2_SET_C:  dec_op = OP_SETB_CARRY;
          OPC2_SET_BE: dec_op = OP_SETB_BELOW_EQ;
          OPC2_SET_Z:  dec_op = OP_SETB_ZERO;
          OPC2_SET_L:  dec_op = OP_SETB_LESS;
          OPC2_SET_LE: dec_op = OP_SETB_LESS_EQ;
          default: begin
            dec_op = OP_NONE;
            dec_base = 8'h00;
          end
        endcase
      end
    end
    if ((dec_op == OP_RESTORE_SEG || dec_op == OP_RESTORE_LDT || dec_op == OP_RESTORE_TASK
         || dec_op == OP_RESUME_MGMT) && !req_i.in_mgmt_mode) begin
      dec_fault = 1'b1;
      dec_base = 8'h00;
    end
  end

  // Sequencer: base phase then one phase per element
  always_comb begin
    state_d    = state_q;
    timer_d    = timer_q;
    iter_start = 1'b0;
    finish     = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (accept && dec_base == 8'h00) begin
          finish = 1'b1;
        end else if (accept) begin
          state_d = ST_BASE;
          timer_d = dec_base - 8'h01;
        end
      end
      ST_BASE: begin
        if (timer_q != 8'h00) begin
          timer_d = timer_q - 8'h01;
        end else if (rpt_q && !cnt_zero) begin
          state_d = ST_ITER;
          timer_d = iter_q - 8'h01;
          iter_start = 1'b1;
        end else begin
          state_d = ST_IDLE;
          finish = 1'b1;
        end
      end
      ST_ITER: begin
        if (timer_q != 8'h00) begin
          timer_d = timer_q - 8'h01;
        end else if (cnt_stop) begin
          state_d = ST_IDLE;
          finish = 1'b1;
        end else begin
          timer_d = iter_q - 8'h01;
          iter_start = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      timer_q <= 8'h00;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  // Handshake and strobes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready_q  <= 1'b0;
      done_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      ready_q  <= (state_d == ST_IDLE);
      done_q   <= finish;
      strobe_q <= (state_d == ST_ITER) && (timer_d == 8'h00);
    end
  end

  // Per-request latches
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      iter_q    <= 8'h00;
      rpt_q     <= 1'b0;
      want_eq_q <= 1'b0;
      prot_q    <= 1'b0;
      priv_q    <= 1'b0;
      by_cl_q   <= 1'b0;
    end else if (accept) begin
      iter_q    <= dec_iter;
      rpt_q     <= (dec_iter != 8'h00);
      want_eq_q <= (dec_op == OP_RPT_EQ_CMP) || (dec_op == OP_RPT_EQ_SCAN);
      prot_q    <= req_i.prot_mode;
      priv_q    <= req_i.priv_change;
      by_cl_q   <= (req_i.opcode[7:1] == OPC_SHF_CL_HI);
    end
  end

  // Clock tally: base plus one iteration cost per element
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clocks_q <= 32'h0000_0000;
      iters_q  <= 32'h0000_0000;
    end else if (accept) begin
      clocks_q <= {24'h00_0000, dec_base};
      iters_q  <= 32'h0000_0000;
    end else if (iter_start) begin
      clocks_q <= clocks_q + {24'h00_0000, iter_q};
      iters_q  <= iters_q + 32'h0000_0001;
    end
  end

  // Result value and flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      res_q <= '0;
    end else if (accept) begin
      res_q.op         <= dec_op;
      res_q.mgmt_fault <= dec_fault;
      res_q.flags      <= req_i.flags;
      res_q.set_value  <= 8'h00;
      case (dec_op)
        OP_SETB_CARRY:    res_q.set_value <= {7'h00, req_i.flags.cf};
        OP_SETB_BELOW_EQ: res_q.set_value <= {7'h00, req_i.flags.cf | req_i.flags.zf};
        OP_SETB_ZERO:     res_q.set_value <= {7'h00, req_i.flags.zf};
        OP_SETB_LESS:     res_q.set_value <= {7'h00, req_i.flags.sf ^ req_i.flags.of};
        OP_SETB_LESS_EQ:
          res_q.set_value <= {7'h00, (req_i.flags.sf ^ req_i.flags.of) | req_i.flags.zf};
        OP_AH_TO_FLAGS: begin
          res_q.flags <= '{of: req_i.flags.of, sf: req_i.accum_high[AH_SF],
                           zf: req_i.accum_high[AH_ZF], af: req_i.accum_high[AH_AF],
                           pf: req_i.accum_high[AH_PF], cf: req_i.accum_high[AH_CF]};
        end
        OP_RESUME_MGMT: begin
          if (!dec_fault) begin
            res_q.flags <= req_i.saved_flags;
          end
        end
        default: begin
          res_q.set_value <= 8'h00;
        end
      endcase
    end
  end

  xrsd_rep_count #(
    .CNT_W (CNT_W)
  ) u_rep_count (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .load_i     (accept),
    .load_val_i (count_i),
    .step_i     (step),
    .want_eq_i  (want_eq_q),
    .elem_eq_i  (elem_eq_i),
    .count_o    (count_o),
    .zero_o     (cnt_zero),
    .stop_o     (cnt_stop)
  );

  assign req_ready_o   = ready_q;
  assign done_o        = done_q;
  assign elem_strobe_o = strobe_q;
  assign clocks_o      = clocks_q;
  assign res_o         = res_q;

  // Busy cycles since accept, for checking
  always_ff @(posedge clk_i) begin
    if (srst_i || accept) begin
      busy_q <= 32'h0000_0000;
    end else if (state_q != ST_IDLE) begin
      busy_q <= busy_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_busy_matches;
    done_o |-> busy_q == clocks_o;
  endproperty
  a_busy_matches: assert property (p_busy_matches) else $error("busy span mismatch");
  property p_eq_cmp;
    done_o && res_o.op == OP_RPT_EQ_CMP |-> clocks_o == 32'd11 + 32'd4 * iters_q;
  endproperty
  a_eq_cmp: assert property (p_eq_cmp) else $error("eq compare count");
  property p_eq_scan;
    done_o && res_o.op == OP_RPT_EQ_SCAN |-> clocks_o == 32'd9 + 32'd3 * iters_q;
  endproperty
  a_eq_scan: assert property (p_eq_scan) else $error("eq scan count");
  property p_ne_cmp;
    elem_strobe_o && res_o.op == OP_RPT_NE_CMP && elem_eq_i |=> done_o && !elem_strobe_o;
  endproperty
  a_ne_cmp: assert property (p_ne_cmp) else $error("ne compare no stop");
  property p_ne_scan;
    done_o && res_o.op == OP_RPT_NE_SCAN |-> clocks_o == 32'd9 + 32'd3 * iters_q;
  endproperty
  a_ne_scan: assert property (p_ne_scan) else $error("ne scan count");
  property p_near;
    done_o && res_o.op == OP_RETURN_NEAR |-> clocks_o == 32'd3;
  endproperty
  a_near: assert property (p_near) else $error("near return count");
  property p_far;
    done_o && res_o.op == OP_RETURN_FAR && !priv_q |-> clocks_o == (prot_q ? 32'd13 : 32'd10);
  endproperty
  a_far: assert property (p_far) else $error("far return count");
  property p_far_priv;
    done_o && res_o.op == OP_RETURN_FAR && prot_q && priv_q |-> clocks_o == 32'd35;
  endproperty
  a_far_priv: assert property (p_far_priv) else $error("priv return count");
  property p_rot;
    done_o && (res_o.op == OP_ROT_LEFT || res_o.op == OP_ROT_RIGHT) |-> busy_q == 32'd2;
  endproperty
  a_rot: assert property (p_rot) else $error("rotate count");
  property p_restore;
    done_o && !res_o.mgmt_fault && (res_o.op == OP_RESTORE_SEG || res_o.op == OP_RESTORE_LDT
      || res_o.op == OP_RESTORE_TASK) |-> clocks_o == 32'd11;
  endproperty
  a_restore: assert property (p_restore) else $error("restore count");
  property p_resume;
    accept && dec_op == OP_RESUME_MGMT && req_i.in_mgmt_mode |-> ##57 !done_o ##1 done_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume count");
  property p_ah;
    accept && ah_op |=> res_o.flags.of == $past(req_i.flags.of)
      && res_o.flags.cf == $past(req_i.accum_high[0]) ##1 done_o;
  endproperty
  a_ah: assert property (p_ah) else $error("ah to flags");
  property p_ash_l;
    done_o && res_o.op == OP_ASHIFT_LEFT |-> clocks_o == (by_cl_q ? 32'd2 : 32'd1);
  endproperty
  a_ash_l: assert property (p_ash_l) else $error("shift left count");
  property p_ash_r;
    done_o && res_o.op == OP_ASHIFT_RIGHT |-> clocks_o == 32'd2;
  endproperty
  a_ash_r: assert property (p_ash_r) else $error("shift right count");
  property p_subb;
    done_o && res_o.op == OP_SUB_BORROW |-> clocks_o == 32'd1;
  endproperty
  a_subb: assert property (p_subb) else $error("borrow count");
  property p_set_c;
    accept && req_i.esc && req_i.opcode == OPC2_SET_C && req_i.reg_field == RF_ZERO
      |=> res_o.set_value == {7'h00, $past(req_i.flags.cf)};
  endproperty
  a_set_c: assert property (p_set_c) else $error("set on carry");
  property p_set_l;
    accept && dec_op == OP_SETB_LESS
      |=> res_o.set_value[0] == ($past(req_i.flags.sf) ^ $past(req_i.flags.of))
      && res_o.flags == $past(req_i.flags);
  endproperty
  a_set_l: assert property (p_set_l) else $error("set on less");
  property p_fault;
    accept && dec_fault |=> done_o && res_o.mgmt_fault && clocks_o == 32'd0;
  endproperty
  a_fault: assert property (p_fault) else $error("mgmt fault");
  property p_count;
    elem_strobe_o && !done_o |=> count_o == $past(count_o) - CNT_W'(1);
  endproperty
  a_count: assert property (p_count) else $error("count step");

  c_multi_iter: cover property (done_o && res_o.op == OP_RPT_EQ_CMP && iters_q > 32'd1);
  c_fault:      cover property (done_o && res_o.mgmt_fault);
  c_far_priv:   cover property (done_o && res_o.op == OP_RETURN_FAR && priv_q);

endmodule : xrsd_decode

// ==== core/xrsd_pkg.sv ====
// Opcodes, clock counts and carrier types for the string/shift/set decode slice
package xrsd_pkg;

  // Prefixes and opcode patterns
  localparam logic [7:0] PFX_RPT_EQ      = 8'hF3;
  localparam logic [7:0] PFX_RPT_NE      = 8'hF2;
  localparam logic [6:0] OPC_CMP_STR_HI  = 7'h53;
  localparam logic [6:0] OPC_SCAN_STR_HI = 7'h57;
  localparam logic [7:0] OPC_RTN_NEAR    = 8'hC3;
  localparam logic [7:0] OPC_RTN_NEAR_IMM= 8'hC2;
  localparam logic [7:0] OPC_RTN_FAR     = 8'hCB;
  localparam logic [7:0] OPC_RTN_FAR_IMM = 8'hCA;
  localparam logic [6:0] OPC_SHF_ONE_HI  = 7'h68;
  localparam logic [6:0] OPC_SHF_CL_HI   = 7'h69;
  localparam logic [6:0] OPC_SHF_IMM_HI  = 7'h60;
  localparam logic [7:0] OPC_AH_FLAGS    = 8'h9E;
  localparam logic [5:0] OPC_SUBB_RM_HI  = 6'h06;
  localparam logic [6:0] OPC_SUBB_ACC_HI = 7'h0E;
  localparam logic [5:0] OPC_ALU_IMM_HI  = 6'h20;
  // Second byte after the 0F escape
  localparam logic [7:0] OPC2_RST_SEG    = 8'h79;
  localparam logic [7:0] OPC2_RST_LDT    = 8'h7B;
  localparam logic [7:0] OPC2_RST_TASK   = 8'h7D;
  localparam logic [7:0] OPC2_RESUME     = 8'hAA;
  localparam logic [7:0] OPC2_SET_C      = 8'h92;
  localparam logic [7:0] OPC2_SET_BE     = 8'h96;
  localparam logic [7:0] OPC2_SET_Z      = 8'h94;
  localparam logic [7:0] OPC2_SET_L      = 8'h9C;
  localparam logic [7:0] OPC2_SET_LE     = 8'h9E;
  // ModR/M register field values
  localparam logic [2:0] RF_ROT_L  = 3'h0;
  localparam logic [2:0] RF_ROT_R  = 3'h1;
  localparam logic [2:0] RF_ASH_L  = 3'h4;
  localparam logic [2:0] RF_ASH_R  = 3'h7;
  localparam logic [2:0] RF_SUBB   = 3'h3;
  localparam logic [2:0] RF_ZERO   = 3'h0;
  // Accumulator high byte flag positions
  localparam int AH_SF = 7;
  localparam int AH_ZF = 6;
  localparam int AH_AF = 4;
  localparam int AH_PF = 2;
  localparam int AH_CF = 0;
  // Clock counts
  localparam logic [7:0] CYC_CMP_BASE  = 8'h0B;
  localparam logic [7:0] CYC_CMP_ITER  = 8'h04;
  localparam logic [7:0] CYC_SCAN_BASE = 8'h09;
  localparam logic [7:0] CYC_SCAN_ITER = 8'h03;
  localparam logic [7:0] CYC_SCAN_ONE  = 8'h02;
  localparam logic [7:0] CYC_RTN_NEAR  = 8'h03;
  localparam logic [7:0] CYC_FAR_REAL  = 8'h0A;
  localparam logic [7:0] CYC_FAR_PROT  = 8'h0D;
  localparam logic [7:0] CYC_FAR_PRIV  = 8'h23;
  localparam logic [7:0] CYC_ROT       = 8'h02;
  localparam logic [7:0] CYC_ASH_L     = 8'h01;
  localparam logic [7:0] CYC_ASH_L_CL  = 8'h02;
  localparam logic [7:0] CYC_ASH_R     = 8'h02;
  localparam logic [7:0] CYC_RESTORE   = 8'h0B;
  localparam logic [7:0] CYC_RESUME    = 8'h39;
  localparam logic [7:0] CYC_ONE       = 8'h01;

  typedef enum logic [4:0] {
    OP_NONE, OP_RPT_EQ_CMP, OP_RPT_EQ_SCAN, OP_RPT_NE_CMP, OP_RPT_NE_SCAN, OP_SCAN,
    OP_RETURN_NEAR, OP_RETURN_FAR, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ASHIFT_LEFT,
    OP_ASHIFT_RIGHT, OP_RESTORE_SEG, OP_RESTORE_LDT, OP_RESTORE_TASK, OP_RESUME_MGMT,
    OP_AH_TO_FLAGS, OP_SUB_BORROW, OP_SETB_CARRY, OP_SETB_BELOW_EQ, OP_SETB_ZERO,
    OP_SETB_LESS, OP_SETB_LESS_EQ
  } xrsd_op_type;

  typedef enum logic [1:0] {ST_IDLE, ST_BASE, ST_ITER} xrsd_state_type;

  typedef struct packed {
    logic of;
    logic sf;
    logic zf;
    logic af;
    logic pf;
    logic cf;
  } xrsd_flags_type;

  typedef struct packed {
    logic [7:0]     prefix;
    logic           esc;
    logic [7:0]     opcode;
    logic [2:0]     reg_field;
    logic           prot_mode;
    logic           priv_change;
    logic           in_mgmt_mode;
    logic [7:0]     accum_high;
    xrsd_flags_type flags;
    xrsd_flags_type saved_flags;
  } xrsd_req_type;

  typedef struct packed {
    xrsd_op_type    op;
    logic           mgmt_fault;
    logic [7:0]     set_value;
    xrsd_flags_type flags;
  } xrsd_res_type;

endpackage : xrsd_pkg

// ==== core/xrsd_rep_count.sv ====
// Iteration counter for repeated string compare and scan
`timescale 1ns/1ps
module xrsd_rep_count #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  input  wire logic             step_i,
  input  wire logic             want_eq_i,
  input  wire logic             elem_eq_i,
  // Status
  output logic      [CNT_W-1:0] count_o,
  output logic                  zero_o,
  output logic                  stop_o
);
  logic [CNT_W-1:0] count_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= load_val_i;
    end else if (step_i) begin
      count_q <= count_q - CNT_W'(1);
    end
  end

  assign count_o = count_q;
  assign zero_o  = (count_q == '0);
  // Ends on last count or failed condition
  assign stop_o  = (count_q == CNT_W'(1)) || (want_eq_i != elem_eq_i);

endmodule : xrsd_rep_count

// ==== verif/xrsd_decode_bench.sv ====
// Self-checking bench for the string/shift/set decode slice
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("Error %s exp %0h got %0h", nm, e, s); end end
module xrsd_decode_bench;
  import xrsd_pkg::*;
  logic           clk_i       = 1'b0;
  logic           srst_i      = 1'b1;
  logic           req_valid_i = 1'b0;
  xrsd_req_type   req_i       = '0;
  logic [31:0]    count_i     = '0;
  logic           elem_eq_i   = 1'b0;
  logic           req_ready_o;
  logic           elem_strobe_o;
  logic           done_o;
  xrsd_res_type   res_o;
  logic [31:0]    clocks_o;
  logic [31:0]    count_o;
  int             fails       = 0;
  int             n_tests     = 0;
  int             cyc         = 0;
  int             f;
  int             k;
  logic [31:0]    rs          = 32'd87751;
  bit             eqs[$];
  logic [2:0]     rfs[4]      = '{3'h0, 3'h1, 3'h4, 3'h7};
  xrsd_op_type    sops[4]     = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_ASHIFT_LEFT, OP_ASHIFT_RIGHT};
  logic [7:0]     forms[3]    = '{8'hD0, 8'hD2, 8'hC0};

  xrsd_decode #(.CNT_W(32)) i_xrsd_decode (.clk_i(clk_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .count_i(count_i), .req_ready_o(req_ready_o),
    .elem_strobe_o(elem_strobe_o), .elem_eq_i(elem_eq_i), .done_o(done_o), .res_o(res_o),
    .clocks_o(clocks_o), .count_o(count_o));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // One instruction: drive, answer element compares, check against the model
  task automatic run(input logic [7:0] pfx, input logic esc, input logic [7:0] opc,
      input logic [2:0] rf, input logic [2:0] mode, input int n, input xrsd_op_type eop,
      input int ecyc, input string nm);
    int             it;
    int             j;
    bit             rep;
    bit             flt;
    bit             d;
    int             ev;
    logic [31:0]    r;
    xrsd_flags_type ef;
    r = rnd();
    eqs.delete();
    it = 0;
    rep = eop inside {OP_RPT_EQ_CMP, OP_RPT_EQ_SCAN, OP_RPT_NE_CMP, OP_RPT_NE_SCAN};
    flt = (eop inside {OP_RESTORE_SEG, OP_RESTORE_LDT, OP_RESTORE_TASK, OP_RESUME_MGMT})
          && !mode[0];
    for (j = 0; rep && j < n; j++) begin
      eqs.push_back(r[j]);
      it++;
      if ((pfx == 8'hF3) ^ r[j]) break;
    end
    #1;
    req_i = {pfx, esc, opc, rf, mode, r[31:24], r[13:8], r[19:14]};
    count_i = n;
    elem_eq_i = (eqs.size() > 0) ? eqs[0] : r[20];
    req_valid_i = 1'b1;
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    #1 req_valid_i = 1'b0;
    d = 1'b0;
    for (j = 0; j < 400 && !d; j++) begin
      @(posedge clk_i);
      d = (done_o === 1'b1);
      if (elem_strobe_o === 1'b1) begin
        void'(eqs.pop_front());
        #1 elem_eq_i = (eqs.size() > 0) ? eqs[0] : r[j % 32];
      end
    end
    `CHK("done", 1'b1, d)
    `CHK("op", eop, res_o.op)
    `CHK("fault", flt, res_o.mgmt_fault)
    ev = rep ? ecyc + it * ((eop inside {OP_RPT_EQ_CMP, OP_RPT_NE_CMP}) ? 4 : 3) : ecyc;
    `CHK("clocks", 32'(flt ? 0 : ev), clocks_o)
    if (rep) `CHK("count", 32'(n - it), count_o)
    ef = req_i.flags;
    if (eop == OP_AH_TO_FLAGS) ef = {ef.of, r[31], r[30], r[28], r[26], r[24]};
    if (eop == OP_RESUME_MGMT) ef = req_i.saved_flags;
    if (eop != OP_NONE && !flt) `CHK("flags", ef, res_o.flags)
    case (eop)
      OP_SETB_CARRY:    ev = ef.cf;
      OP_SETB_BELOW_EQ: ev = ef.cf | ef.zf;
      OP_SETB_ZERO:     ev = ef.zf;
      OP_SETB_LESS:     ev = ef.sf ^ ef.of;
      OP_SETB_LESS_EQ:  ev = (ef.sf ^ ef.of) | ef.zf;
      default:          ev = 2;
    endcase
    if (ev != 2) `CHK("set", 8'(ev), res_o.set_value)
    $display("done %s", nm);
  endtask : run

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    for (k = 0; k < 9; k += 4) begin
      run(8'hF3, 0, 8'hA6, 0, 3'h4, k, OP_RPT_EQ_CMP, 11, "rpt_eq_cmp");
      run(8'hF3, 0, 8'hAF, 0, 3'h0, k, OP_RPT_EQ_SCAN, 9, "rpt_eq_scan");
      run(8'hF2, 0, 8'hA7, 0, 3'h0, k, OP_RPT_NE_CMP, 11, "rpt_ne_cmp");
      run(8'hF2, 0, 8'hAE, 0, 3'h4, k, OP_RPT_NE_SCAN, 9, "rpt_ne_scan");
    end
    run(8'h00, 0, 8'hC2, 0, 3'h4, 0, OP_RETURN_NEAR, 3, "near");
    run(8'h00, 0, 8'hC3, 0, 3'h0, 0, OP_RETURN_NEAR, 3, "near_plain");
    run(8'h00, 0, 8'hCB, 0, 3'h2, 0, OP_RETURN_FAR, 10, "far_real");
    run(8'h00, 0, 8'hCA, 0, 3'h4, 0, OP_RETURN_FAR, 13, "far_prot");
    run(8'h00, 0, 8'hCB, 0, 3'h6, 0, OP_RETURN_FAR, 35, "far_priv");
    for (k = 0; k < 12; k++) begin
      f = k / 4;
      run(8'h00, 0, forms[f] | 8'(rnd() & 1), rfs[k % 4], 3'h0, 0, sops[k % 4],
          (k % 4 == 2 && f != 1) ? 1 : 2, "shift");
    end
    for (k = 0; k < 2; k++) begin
      run(8'h00, 1, 8'h79, 3'(rnd()), 3'(k), 0, OP_RESTORE_SEG, 11, "rst_seg");
      run(8'h00, 1, 8'h7B, 0, 3'(k), 0, OP_RESTORE_LDT, 11, "rst_ldt");
      run(8'h00, 1, 8'h7D, 0, 3'(k), 0, OP_RESTORE_TASK, 11, "rst_task");
      run(8'h00, 1, 8'hAA, 0, 3'(k), 0, OP_RESUME_MGMT, 57, "resume");
    end
    run(8'h00, 0, 8'h9E, 0, 3'h0, 0, OP_AH_TO_FLAGS, 1, "ah_flags");
    run(8'h00, 0, 8'h1A, 5, 3'h0, 0, OP_SUB_BORROW, 1, "sbb_rm");
    run(8'h00, 0, 8'h83, 3, 3'h4, 0, OP_SUB_BORROW, 1, "sbb_imm");
    run(8'h00, 0, 8'h1D, 0, 3'h0, 0, OP_SUB_BORROW, 1, "sbb_acc");
    for (k = 0; k < 4; k++) begin
      run(8'h00, 1, 8'h92, 0, 3'h0, 0, OP_SETB_CARRY, 1, "set_c");
      run(8'h00, 1, 8'h96, 0, 3'h0, 0, OP_SETB_BELOW_EQ, 1, "set_be");
      run(8'h00, 1, 8'h94, 0, 3'h0, 0, OP_SETB_ZERO, 1, "set_z");
      run(8'h00, 1, 8'h9C, 0, 3'h0, 0, OP_SETB_LESS, 1, "set_l");
      run(8'h00, 1, 8'h9E, 0, 3'h0, 0, OP_SETB_LESS_EQ, 1, "set_le");
    end
    run(8'h66, 0, 8'hA6, 0, 3'h0, 3, OP_NONE, 0, "bad_prefix");
    run(8'h00, 0, 8'hAE, 0, 3'h0, 0, OP_SCAN, 2, "plain_scan");
    report_and_stop();
  end
endmodule : xrsd_decode_bench
